//--- include/watchdog_pkg.sv
// Summary of operation
// - Source is low-speed clock or system clock/4.
// - Low-speed clock from crystal or internal oscillator.
// - Timeout is 2^(13+code) source clock periods.
// - Control bit 7 keeps system clock in idle.
// - Disabled only if option off and key 1010.
// - Power-on: key 1010, select 111, bit7 zero.
// - Disabled watchdog turns its instructions into no-ops.
// - Normal overflow resets device, sets time-out flag.
// - Low-power overflow clears only PC and SP.
// - Count cleared by reset pin, clears, halt.
// - Single style: one clear instruction clears count.
// - Dual style: only alternating clears clear count.
// - System/4 source stops in sleep and idle_mode_clock_off.
// - Low-power overflow also wakes the device.
package watchdog_pkg;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned SYS_DIV = 4;
    localparam logic [7:0] CTRL_RESET = 8'h7a;
    localparam int unsigned SYSON_BIT = 7;
    localparam int unsigned WS_MSB = 6;
    localparam int unsigned WS_LSB = 4;
    localparam int unsigned KEY_MSB = 3;
    localparam int unsigned KEY_LSB = 0;
    localparam logic [3:0] KEY_DISABLE = 4'ha;
    localparam logic [3:0] KEY_SUGGEST = 4'h5;
    localparam logic [2:0] WS_MAX = 3'h7;
    localparam logic [CNT_W-1:0] CNT_MAX = 20'hfffff;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_STATE = 12'h00c;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_TIMEOUT = 0;
    localparam int unsigned IRQ_CLEARED = 1;
    localparam int unsigned IRQ_REFUSED = 2;
    localparam int unsigned STATE_FLAG_BIT = 20;
    localparam int unsigned STATE_EN_BIT = 21;
    localparam int unsigned STATE_RUN_BIT = 22;

    typedef enum logic [1:0] {
        CLR_NONE = 2'b00,
        CLR_FIRST = 2'b01,
        CLR_SECOND = 2'b10
    } clr_state_t;
endpackage

//--- rtl/wdt_tick_div.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_tick_div
    import watchdog_pkg::*;
#(
    parameter int unsigned DIV = SYS_DIV
) (
    input wire logic sys_clk_i, // System clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic run_i, // System clock is running
    output logic tick_o // One pulse per DIV running cycles
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (run_i) begin
            if (cnt == LAST) begin
                next_cnt = '0;
                next_tick = 1'b1;
            end else begin
                next_cnt = W'(cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule
`default_nettype wire

//--- rtl/wdt_clear_seq.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_clear_seq
    import watchdog_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic enable_i, // Watchdog enabled
    input wire logic dual_i, // Dual-instruction clear style
    input wire logic single_i, // Single clear instruction executed
    input wire logic first_i, // First clear instruction executed
    input wire logic second_i, // Second clear instruction executed
    output logic clear_o, // Accepted clear, combinational
    output logic refused_o // Repeated dual clear ignored
);
    clr_state_t last;
    clr_state_t next_last;

    always_comb begin
        next_last = last;
        clear_o = 1'b0;
        refused_o = 1'b0;
        if (enable_i) begin
            if (!dual_i) begin
                clear_o = single_i;
            end else if (first_i) begin
                if (last != CLR_FIRST) begin
                    clear_o = 1'b1;
                    next_last = CLR_FIRST;
                end else begin
                    refused_o = 1'b1;
                end
            end else if (second_i) begin
                if (last != CLR_SECOND) begin
                    clear_o = 1'b1;
                    next_last = CLR_SECOND;
                end else begin
                    refused_o = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last <= CLR_NONE;
        end else begin
            last <= next_last;
        end
    end
endmodule
`default_nettype wire

//--- rtl/watchdog_timer_unit.sv
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_unit
    import watchdog_pkg::*;
(
    input wire logic sys_clk_i, // System clock, 100 MHz
    input wire logic resetn_i, // Async power-on reset, active low
    // APB slave
    input wire logic psel_i, // Select
    input wire logic penable_i, // Access phase
    input wire logic pwrite_i, // Write when high
    input wire logic [ADDR_W-1:0] paddr_i, // Byte address
    input wire logic [31:0] pwdata_i, // Write data
    output logic [31:0] prdata_o, // Read data
    output logic pready_o, // Transfer done
    output logic pslverr_o, // Unmapped address
    // Fixed configuration options
    input wire logic cfg_wdt_enable_i, // Option: watchdog enabled
    input wire logic cfg_src_low_speed_i, // Option: 1 low-speed, 0 system/4
    input wire logic cfg_sub_crystal_i, // Option: 1 crystal, 0 internal osc
    input wire logic cfg_dual_clear_i, // Option: dual clear style
    // Clock ticks and pins
    input wire logic ext_crystal_32k_tick_i, // One pulse per crystal period
    input wire logic int_low_osc_tick_i, // One pulse per internal osc period
    input wire logic ext_low_active_pin_n_i, // External reset pin, active low
    // Core events
    input wire logic clear_watchdog_single_i, // Single clear executed
    input wire logic clear_watchdog_first_i, // First clear executed
    input wire logic clear_watchdog_second_i, // Second clear executed
    input wire logic halt_i, // Halt executed
    input wire logic sleep_mode_i, // Core is in sleep
    input wire logic idle_mode_i, // Core is in idle
    // Results
    output logic system_clock_run_o, // System clock allowed to run
    output logic sysclk_keep_in_idle_o, // Control bit 7
    output logic device_reset_o, // Full reset request pulse
    output logic pc_sp_clear_o, // Clear PC and SP pulse
    output logic wake_o, // Wake from low power pulse
    output logic timeout_flag_o, // Time-out flag
    output logic irq_o // Interrupt, level
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] watchdog_control;
    logic [7:0] next_watchdog_control;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic timeout_flag;
    logic next_timeout_flag;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_device_reset;
    logic next_pc_sp_clear;
    logic next_wake;
    logic next_irq;
    logic enabled;
    logic low_power;
    logic sys_running;
    logic div_tick;
    logic src_tick;
    logic instr_clear;
    logic refused;
    logic clear_cnt;
    logic overflow;
    logic [CNT_W-1:0] limit;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [2:0] timeout_select;
    logic [3:0] soft_disable_key;
    logic [IRQ_W-1:0] events;

    ////////////////////////////////////////////////////////////////////////////
    // Enable, clock source and clear
    assign timeout_select = watchdog_control[WS_MSB:WS_LSB];
    assign soft_disable_key = watchdog_control[KEY_MSB:KEY_LSB];
    assign enabled = cfg_wdt_enable_i || (soft_disable_key != KEY_DISABLE);
    assign low_power = sleep_mode_i || idle_mode_i;
    // System clock stops in sleep, and in idle unless bit 7 keeps it
    assign sys_running = !(sleep_mode_i || (idle_mode_i && !watchdog_control[SYSON_BIT]));

    wdt_tick_div #(
        .DIV(SYS_DIV)
    ) u_div (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .run_i(sys_running),
        .tick_o(div_tick)
    );

    always_comb begin
        if (cfg_src_low_speed_i) begin
            src_tick = cfg_sub_crystal_i ? ext_crystal_32k_tick_i : int_low_osc_tick_i;
        end else begin
            src_tick = div_tick;
        end
    end

    wdt_clear_seq u_clr (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .enable_i(enabled),
        .dual_i(cfg_dual_clear_i),
        .single_i(clear_watchdog_single_i),
        .first_i(clear_watchdog_first_i),
        .second_i(clear_watchdog_second_i),
        .clear_o(instr_clear),
        .refused_o(refused)
    );

    assign clear_cnt = !ext_low_active_pin_n_i || instr_clear || (halt_i && enabled);

    ////////////////////////////////////////////////////////////////////////////
    // Counter
    assign limit = CNT_MAX >> (WS_MAX - timeout_select);

    always_comb begin
        next_count = count;
        overflow = 1'b0;
        if (!enabled || clear_cnt) begin
            next_count = '0;
        end else if (src_tick) begin
            if (count == limit) begin
                next_count = '0;
                overflow = 1'b1;
            end else begin
                next_count = CNT_W'(count + 1'b1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow actions and time-out flag
    always_comb begin
        next_device_reset = overflow && !low_power;
        next_pc_sp_clear = overflow && low_power;
        next_wake = overflow && low_power;
        next_timeout_flag = timeout_flag;
        if (instr_clear || (halt_i && enabled)) begin
            next_timeout_flag = 1'b0;
        end
        if (overflow) begin
            next_timeout_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            device_reset_o <= 1'b0;
            pc_sp_clear_o <= 1'b0;
            wake_o <= 1'b0;
            timeout_flag <= 1'b0;
        end else begin
            device_reset_o <= next_device_reset;
            pc_sp_clear_o <= next_pc_sp_clear;
            wake_o <= next_wake;
            timeout_flag <= next_timeout_flag;
        end
    end

    assign timeout_flag_o = timeout_flag;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode and registers
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
    assign rd_en = psel_i && penable_i && !pready_o && !pwrite_i;
    assign mapped = (paddr_i == OFF_CTRL) || (paddr_i == OFF_IRQ_STATUS)
                    || (paddr_i == OFF_IRQ_MASK) || (paddr_i == OFF_STATE);

    assign events[IRQ_TIMEOUT] = overflow;
    assign events[IRQ_CLEARED] = instr_clear;
    assign events[IRQ_REFUSED] = refused;

    always_comb begin
        next_watchdog_control = watchdog_control;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr_en && paddr_i == OFF_CTRL) begin
            next_watchdog_control = pwdata_i[7:0];
        end
        if (wr_en && paddr_i == OFF_IRQ_MASK) begin
            next_irq_mask = pwdata_i[IRQ_W-1:0];
        end
        if (wr_en && paddr_i == OFF_IRQ_STATUS) begin
            next_irq_status = irq_status & ~pwdata_i[IRQ_W-1:0];
        end
        // A new event wins over a clear in the same cycle
        next_irq_status = next_irq_status | events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            watchdog_control <= CTRL_RESET;
            irq_mask <= '0;
            irq_status <= '0;
            irq_o <= 1'b0;
            sysclk_keep_in_idle_o <= 1'b0;
            system_clock_run_o <= 1'b1;
        end else begin
            watchdog_control <= next_watchdog_control;
            irq_mask <= next_irq_mask;
            irq_status <= next_irq_status;
            irq_o <= next_irq;
            sysclk_keep_in_idle_o <= next_watchdog_control[SYSON_BIT];
            system_clock_run_o <= sys_running;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait cycle in the access phase
    always_comb begin
        next_pready = psel_i && penable_i && !pready_o;
        next_pslverr = next_pready && !mapped;
        next_prdata = '0;
        if (rd_en) begin
            unique case (paddr_i)
                OFF_CTRL: next_prdata = {24'h000000, watchdog_control};
                OFF_IRQ_STATUS: next_prdata = {{(32 - IRQ_W){1'b0}}, irq_status};
                OFF_IRQ_MASK: next_prdata = {{(32 - IRQ_W){1'b0}}, irq_mask};
                OFF_STATE: begin
                    next_prdata[CNT_W-1:0] = count;
                    next_prdata[STATE_FLAG_BIT] = timeout_flag;
                    next_prdata[STATE_EN_BIT] = enabled;
                    next_prdata[STATE_RUN_BIT] = sys_running;
                end
                default: next_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
            prdata_o <= next_prdata;
        end
    end
endmodule
`default_nettype wire

//--- dv/wdt_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_monitor
    import watchdog_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic resetn_i, // Reset
    input wire logic psel_i, // Select
    input wire logic penable_i, // Access
    input wire logic pwrite_i, // Write
    input wire logic [ADDR_W-1:0] paddr_i, // Address
    input wire logic [31:0] pwdata_i, // Write data
    input wire logic pready_o, // Ready
    input wire logic pslverr_o, // Error
    input wire logic sleep_mode_i, // Sleep
    input wire logic idle_mode_i, // Idle
    input wire logic ext_low_active_pin_n_i, // Pin
    input wire logic device_reset_o, // Full reset
    input wire logic pc_sp_clear_o, // Partial reset
    input wire logic wake_o, // Wake
    input wire logic timeout_flag_o, // Flag
    input wire logic system_clock_run_o, // Run
    input wire logic sysclk_keep_in_idle_o // Bit 7
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    logic lp;
    assign lp = sleep_mode_i || idle_mode_i;
    ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready late");
    ready_pulse_a: assert property (pready_o |-> psel_i && penable_i ##1 !pready_o)
        else $error("ready not a pulse");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    full_reset_a: assert property (device_reset_o |-> !lp && timeout_flag_o)
        else $error("bad full reset");
    partial_reset_a: assert property (pc_sp_clear_o |-> lp && wake_o && timeout_flag_o)
        else $error("bad partial reset");
    wake_pair_a: assert property (wake_o |-> pc_sp_clear_o && !device_reset_o)
        else $error("bad wake");
    one_overflow_a: assert property (device_reset_o || pc_sp_clear_o |=> !(device_reset_o || pc_sp_clear_o))
        else $error("overflow repeated");
    pin_hold_a: assert property (!ext_low_active_pin_n_i [*2] |=> !device_reset_o && !pc_sp_clear_o)
        else $error("overflow under pin");
    sleep_stop_a: assert property (sleep_mode_i [*2] |-> !system_clock_run_o)
        else $error("clock runs in sleep");
    keep_write_a: assert property (psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFF_CTRL
        |=> ##1 sysclk_keep_in_idle_o == $past(pwdata_i[SYSON_BIT], 2))
        else $error("bit 7 not copied");
    cover property (device_reset_o);
    cover property (pc_sp_clear_o);
    cover property (pslverr_o);
endmodule
`default_nettype wire

//--- dv/watchdog_timer_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_unit_tb
    import watchdog_pkg::*;
;
    logic sys_clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [ADDR_W-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o;
    logic cfg_wdt_enable_i = 0, cfg_src_low_speed_i = 1, cfg_sub_crystal_i = 1;
    logic cfg_dual_clear_i = 0, ext_crystal_32k_tick_i = 0, int_low_osc_tick_i = 0;
    logic ext_low_active_pin_n_i = 1, clear_watchdog_single_i = 0, clear_watchdog_first_i = 0;
    logic clear_watchdog_second_i = 0, halt_i = 0, sleep_mode_i = 0, idle_mode_i = 0;
    logic pready_o, pslverr_o, system_clock_run_o, sysclk_keep_in_idle_o;
    logic device_reset_o, pc_sp_clear_o, wake_o, timeout_flag_o, irq_o;
    logic [64:0] q[$];
    logic [64:0] e;
    logic [3:0] k;
    int failures = 0, comparisons = 0, cyc = 0, n_rst = 0, n_pc = 0;
    watchdog_timer_unit i_dut (.*);
    always #5 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (x !== g) begin
            failures++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask
    task chkb(input logic x, input logic g);
        chk({31'h0, x}, {31'h0, g});
    endtask
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [31:0] x, input logic [31:0] m, input logic r);
        q.push_back({r, m, x});
        @(posedge sys_clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task rc(input logic [19:0] c);
        apb(0, OFF_STATE, 0, {12'h0, c}, 32'hfffff, 0);
    endtask
    task tk(input int n, input logic s);
        repeat (n) begin
            @(posedge sys_clk_i);
            ext_crystal_32k_tick_i <= s;
            int_low_osc_tick_i <= !s;
        end
        @(posedge sys_clk_i);
        ext_crystal_32k_tick_i <= 0;
        int_low_osc_tick_i <= 0;
    endtask
    task ins(input int n);
        @(posedge sys_clk_i);
        {halt_i, clear_watchdog_second_i, clear_watchdog_first_i, clear_watchdog_single_i} <= 4'h1 << n;
        @(posedge sys_clk_i);
        {halt_i, clear_watchdog_second_i, clear_watchdog_first_i, clear_watchdog_single_i} <= 4'h0;
    endtask
    task w3;
        repeat (3) @(posedge sys_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_i) begin
        if (pready_o === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            chk(e[31:0] & e[63:32], prdata_o & e[63:32]);
            chkb(e[64], pslverr_o);
        end
        if (device_reset_o === 1'b1)
            n_rst++;
        if (pc_sp_clear_o === 1'b1 && wake_o === 1'b1)
            n_pc++;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            end_sim;
        end
    end
    initial begin
        void'($urandom(84));
        k = 4'($urandom);
        if (k == KEY_DISABLE)
            k = KEY_SUGGEST;
        w3;
        resetn_i <= 1;
        apb(0, OFF_CTRL, 0, 32'h7a, 32'hff, 0);
        chkb(0, sysclk_keep_in_idle_o);
        apb(0, 12'h010, 0, 0, 32'hffffffff, 1);
        tk(20, 1);
        apb(0, OFF_STATE, 0, 0, 32'h2fffff, 0);
        ins(0);
        ins(3);
        apb(0, OFF_IRQ_STATUS, 0, 0, 32'h2, 0);
        apb(1, OFF_CTRL, {24'h0, 4'h8, k}, 0, 0, 0);
        apb(1, OFF_IRQ_MASK, 32'h7, 0, 0, 0);
        chkb(1, sysclk_keep_in_idle_o);
        tk(8191, 1);
        rc(20'h01fff);
        chk(0, n_rst);
        tk(1, 1);
        w3;
        chk(1, n_rst);
        chkb(1, timeout_flag_o);
        chkb(1, irq_o);
        rc(0);
        apb(1, OFF_IRQ_STATUS, 32'h7, 0, 0, 0);
        w3;
        chkb(0, irq_o);
        apb(1, OFF_CTRL, {24'h0, 4'h9, k}, 0, 0, 0);
        apb(1, OFF_IRQ_MASK, 32'h6, 0, 0, 0);
        sleep_mode_i <= 1;
        tk(16383, 1);
        chk(0, n_pc);
        tk(1, 1);
        w3;
        chk(1, n_pc);
        chk(1, n_rst);
        chkb(0, irq_o);
        sleep_mode_i <= 0;
        tk(9, 1);
        ins(0);
        rc(0);
        chkb(0, timeout_flag_o);
        apb(0, OFF_IRQ_STATUS, 0, 32'h3, 32'h3, 0);
        tk(30, 0);
        cfg_sub_crystal_i <= 0;
        tk(5, 0);
        rc(20'h5);
        cfg_dual_clear_i <= 1;
        ins(0);
        rc(20'h5);
        ins(1);
        rc(0);
        tk(4, 0);
        ins(1);
        rc(20'h4);
        apb(0, OFF_IRQ_STATUS, 0, 32'h4, 32'h4, 0);
        ins(2);
        rc(0);
        tk(7, 0);
        ins(3);
        rc(0);
        tk(7, 0);
        ext_low_active_pin_n_i <= 0;
        repeat (2) @(posedge sys_clk_i);
        ext_low_active_pin_n_i <= 1;
        rc(0);
        cfg_src_low_speed_i <= 0;
        sleep_mode_i <= 1;
        ins(3);
        repeat (60) @(posedge sys_clk_i);
        rc(0);
        chkb(0, system_clock_run_o);
        sleep_mode_i <= 0;
        idle_mode_i <= 1;
        w3;
        chkb(1, system_clock_run_o);
        apb(1, OFF_CTRL, {24'h0, 4'h1, k}, 0, 0, 0);
        w3;
        chkb(0, system_clock_run_o);
        idle_mode_i <= 0;
        ins(1);
        repeat (404) @(posedge sys_clk_i);
        apb(0, OFF_STATE, 0, 32'h64, 32'hffffc, 0);
        end_sim;
    end
endmodule
bind watchdog_timer_unit wdt_monitor i_mon (.*);
`default_nettype wire
